// >>> pkg/pin_share_regs.vh
/*
  Constants for the socket pin sharing and power link block: control bit
  positions, socket mode codes, timing figures and reset values.
  Assumes inclusion by bare name from design files under hw/.
*/
`ifndef PIN_SHARE_REGS_VH
`define PIN_SHARE_REGS_VH

// ----------------------------------------------------------------
// Control word (vendor control register, held as plain ports)
// ----------------------------------------------------------------
`define CTL2_OFFSET 8'hD4
`define CTL2_LINK_CLK_OUT_BIT 13

// ----------------------------------------------------------------
// Socket mode codes
// ----------------------------------------------------------------
`define MODE_CARD16 2'h0
`define MODE_ATA 2'h1
`define MODE_CARDBUS 2'h2
`define MODE_IDLE 2'h3

// ----------------------------------------------------------------
// Power link timing
// ----------------------------------------------------------------
`define CLK_HZ 40000000
`define LINK_HZ_MIN 10000
`define LINK_HZ_MAX 100000
`define LINK_HZ_TYP 32000
`define LINK_HALF_CYC ((`CLK_HZ + 2 * `LINK_HZ_TYP - 1) / (2 * `LINK_HZ_TYP))
`define LINK_WORD_BITS 4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_ADDR_HI 10'h000

`endif

// >>> hw/power_link_serial.v
/*
  Serial power switch link: shifts a control word out on the data pin,
  one bit per link clock falling edge, then strobes the latch pin.
  Assumes link_clk_rise/fall are one-cycle pulses on ref_clk.
*/
`default_nettype none
`include "pin_share_regs.vh"

module power_link_serial #(
  parameter WORD_BITS = `LINK_WORD_BITS
) (
  input wire ref_clk,
  input wire nrst,
  input wire link_clk_fall,
  input wire link_clk_rise,
  input wire [WORD_BITS-1:0] word,
  output reg data,
  output reg latch,
  output reg busy
);

  // ----------------------------------------------------------------
  // Shifter
  // ----------------------------------------------------------------
  localparam CW = 5;
  reg [WORD_BITS-1:0] sent;
  reg [WORD_BITS-1:0] shreg;
  reg [CW-1:0] left;

  // A new word starts only when idle, so the switch never sees half a word
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sent <= {WORD_BITS{1'b0}};
      shreg <= {WORD_BITS{1'b0}};
      left <= 5'h00;
      data <= 1'b0;
      latch <= 1'b0;
      busy <= 1'b0;
    end else if (!busy) begin
      latch <= 1'b0;
      if (word != sent && link_clk_fall) begin
        busy <= 1'b1;
        sent <= word;
        shreg <= word;
        left <= WORD_BITS[CW-1:0];
      end
    end else if (link_clk_fall) begin
      if (left != 5'h00) begin
        data <= shreg[WORD_BITS-1];
        shreg <= {shreg[WORD_BITS-2:0], 1'b0};
        left <= left - 5'h01;
      end else begin
        latch <= 1'b1;
      end
    end else if (link_clk_rise && latch) begin
      latch <= 1'b0;
      busy <= 1'b0;
    end
  end

endmodule // power_link_serial
`default_nettype wire

// >>> hw/socket_pin_sharing.v
/*
  Socket pin sharing and power switch link. Selects 16-bit card or
  CardBus functions for the shared socket pins from one mode state and
  drives the power switch in parallel or serial form.
  Assumes card cycle controls come from ref_clk logic; link clock and
  socket pins are asynchronous and are synchronised here.
*/
`default_nettype none
`include "pin_share_regs.vh"

module socket_pin_sharing #(
  parameter HALF_CYC = `LINK_HALF_CYC
) (
  input wire ref_clk,
  input wire nrst,
  // Configuration and status
  input wire [1:0] socket_mode_req,
  input wire [15:0] ctl2,
  input wire serial_power,
  input wire [3:0] power_word,
  output reg [1:0] socket_mode,
  output reg link_busy,
  // 16-bit card cycle controls
  input wire [25:16] card_addr,
  input wire mem_cycle,
  input wire io_cycle,
  input wire dma_cycle,
  input wire attr_space,
  input wire dma_ack,
  // CardBus side
  input wire [2:0] cad_out,
  input wire [2:0] cad_oe,
  input wire cframe_n_out,
  input wire ctrdy_n_out,
  input wire cdevsel_n_out,
  input wire cstop_n_out,
  input wire cblock_n_out,
  input wire cbctl_oe,
  input wire ccbe3_n_out,
  input wire ccbe_oe,
  input wire card_clk_en,
  output reg [2:0] cad_in,
  output reg cframe_n_in,
  output reg ctrdy_n_in,
  output reg cdevsel_n_in,
  output reg cstop_n_in,
  output reg cblock_n_in,
  // Shared socket pins addr 25..16 and attribute select
  input wire [25:16] sock_addr_in,
  output reg [25:16] sock_addr_out,
  output reg [25:16] sock_addr_oe,
  input wire attr_sel_n_in,
  output reg attr_sel_n_out,
  output reg attr_sel_n_oe,
  // Power switch pins
  output reg prog_voltage_ctl0,
  output reg prog_voltage_ctl0_oe,
  output reg prog_voltage_ctl1,
  output reg supply_select0_n,
  output reg supply_select0_n_oe,
  input wire link_clk_in,
  output reg supply_select1_n,
  output reg supply_select1_n_oe
);

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  function is_cardbus;
    input [1:0] m;
    begin
      is_cardbus = (m == `MODE_CARDBUS);
    end
  endfunction

  function is_card16;
    input [1:0] m;
    begin
      is_card16 = (m == `MODE_CARD16) || (m == `MODE_ATA);
    end
  endfunction

  wire link_clk_drive = ctl2[`CTL2_LINK_CLK_OUT_BIT];

  // ----------------------------------------------------------------
  // Synchronisers for pins from outside the clock domain
  // ----------------------------------------------------------------
  reg [25:16] addr_s1;
  reg [25:16] addr_s2;
  reg attr_s1;
  reg attr_s2;
  reg lclk_s1;
  reg lclk_s2;
  reg lclk_d;

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      addr_s1 <= 10'h3FF;
      addr_s2 <= 10'h3FF;
      attr_s1 <= 1'b1;
      attr_s2 <= 1'b1;
      lclk_s1 <= 1'b0;
      lclk_s2 <= 1'b0;
      lclk_d <= 1'b0;
    end else begin
      addr_s1 <= sock_addr_in;
      addr_s2 <= addr_s1;
      attr_s1 <= attr_sel_n_in;
      attr_s2 <= attr_s1;
      lclk_s1 <= link_clk_in;
      lclk_s2 <= lclk_s1;
      lclk_d <= lclk_s2;
    end
  end

  // ----------------------------------------------------------------
  // Link clock: own divider when driving, sampled pin otherwise
  // ----------------------------------------------------------------
  reg [15:0] div_cnt;
  reg div_clk;
  reg div_d;

  // The divider runs at the typical rate, inside the allowed band
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      div_cnt <= 16'h0000;
      div_clk <= 1'b0;
      div_d <= 1'b0;
    end else begin
      div_d <= div_clk;
      if (div_cnt >= HALF_CYC[15:0] - 16'h0001) begin
        div_cnt <= 16'h0000;
        div_clk <= ~div_clk;
      end else begin
        div_cnt <= div_cnt + 16'h0001;
      end
    end
  end

  wire lclk_now = link_clk_drive ? div_clk : lclk_s2;
  wire lclk_old = link_clk_drive ? div_d : lclk_d;
  wire lclk_fall = lclk_old & ~lclk_now;
  wire lclk_rise = ~lclk_old & lclk_now;
  wire ser_data;
  wire ser_latch;
  wire ser_busy;

  power_link_serial #(
    .WORD_BITS(`LINK_WORD_BITS)
  ) u_link (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .link_clk_fall(lclk_fall & serial_power),
    .link_clk_rise(lclk_rise & serial_power),
    .word(power_word),
    .data(ser_data),
    .latch(ser_latch),
    .busy(ser_busy)
  );

  // ----------------------------------------------------------------
  // Socket mode state
  // ----------------------------------------------------------------
  // Mode changes only pass through idle so no pin ever carries both roles
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      socket_mode <= `MODE_IDLE;
    end else if (socket_mode_req != socket_mode) begin
      if (socket_mode == `MODE_IDLE || socket_mode_req == `MODE_IDLE) begin
        socket_mode <= socket_mode_req;
      end else begin
        socket_mode <= `MODE_IDLE;
      end
    end
  end

  // ----------------------------------------------------------------
  // Next pin values
  // ----------------------------------------------------------------
  reg [25:16] next_addr_out;
  reg [25:16] next_addr_oe;
  reg next_attr_out;
  reg next_attr_oe;

  always @* begin
    next_addr_out = `RST_ADDR_HI;
    next_addr_oe = 10'h000;
    next_attr_out = 1'b1;
    next_attr_oe = 1'b0;
    case (socket_mode)
      `MODE_CARD16, `MODE_ATA: begin
        next_addr_out = card_addr;
        next_addr_oe = 10'h3FF;
        next_attr_oe = 1'b1;
        if (socket_mode == `MODE_ATA) begin
          next_attr_out = 1'b1;
        end else if (dma_cycle) begin
          next_attr_out = ~dma_ack;
        end else if (io_cycle) begin
          next_attr_out = 1'b0;
        end else if (mem_cycle) begin
          next_attr_out = ~attr_space;
        end
      end
      `MODE_CARDBUS: begin
        next_addr_out[25] = cad_out[2];
        next_addr_out[24] = cad_out[1];
        next_addr_out[17] = cad_out[0];
        next_addr_oe[25] = cad_oe[2];
        next_addr_oe[24] = cad_oe[1];
        next_addr_oe[17] = cad_oe[0];
        next_addr_out[23] = cframe_n_out;
        next_addr_out[22] = ctrdy_n_out;
        next_addr_out[21] = cdevsel_n_out;
        next_addr_out[20] = cstop_n_out;
        next_addr_out[19] = cblock_n_out;
        next_addr_oe[23:19] = {5{cbctl_oe}};
        next_addr_out[16] = div_clk & card_clk_en;
        next_addr_oe[16] = 1'b1;
        next_addr_oe[18] = 1'b0;
        next_attr_out = ccbe3_n_out;
        next_attr_oe = ccbe_oe;
      end
      default: begin
        next_addr_oe = 10'h000;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registered socket pins and CardBus receive side
  // ----------------------------------------------------------------
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sock_addr_out <= `RST_ADDR_HI;
      sock_addr_oe <= 10'h000;
      attr_sel_n_out <= 1'b1;
      attr_sel_n_oe <= 1'b0;
      cad_in <= 3'h0;
      cframe_n_in <= 1'b1;
      ctrdy_n_in <= 1'b1;
      cdevsel_n_in <= 1'b1;
      cstop_n_in <= 1'b1;
      cblock_n_in <= 1'b1;
    end else begin
      sock_addr_out <= next_addr_out;
      sock_addr_oe <= next_addr_oe;
      attr_sel_n_out <= next_attr_out;
      attr_sel_n_oe <= next_attr_oe;
      // Receive side reads idle unless CardBus, so 16-bit traffic never leaks in
      if (is_cardbus(socket_mode)) begin
        cad_in <= {addr_s2[25], addr_s2[24], addr_s2[17]};
        cframe_n_in <= addr_s2[23];
        ctrdy_n_in <= addr_s2[22];
        cdevsel_n_in <= addr_s2[21];
        cstop_n_in <= addr_s2[20];
        cblock_n_in <= addr_s2[19];
      end else begin
        cad_in <= 3'h0;
        cframe_n_in <= 1'b1;
        ctrdy_n_in <= 1'b1;
        cdevsel_n_in <= 1'b1;
        cstop_n_in <= 1'b1;
        cblock_n_in <= attr_s2 | ~attr_s2;
      end
    end
  end

  // ----------------------------------------------------------------
  // Power switch pins
  // ----------------------------------------------------------------
  // Serial mode reuses three parallel pins; the fourth stays a parallel line
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      prog_voltage_ctl0 <= 1'b0;
      prog_voltage_ctl0_oe <= 1'b0;
      prog_voltage_ctl1 <= 1'b0;
      supply_select0_n <= 1'b1;
      supply_select0_n_oe <= 1'b0;
      supply_select1_n <= 1'b1;
      supply_select1_n_oe <= 1'b0;
      link_busy <= 1'b0;
    end else begin
      link_busy <= ser_busy & serial_power;
      if (serial_power) begin
        prog_voltage_ctl0 <= ser_latch;
        prog_voltage_ctl0_oe <= 1'b1;
        prog_voltage_ctl1 <= power_word[1];
        supply_select0_n <= ser_data;
        supply_select0_n_oe <= 1'b1;
        supply_select1_n <= div_clk;
        supply_select1_n_oe <= link_clk_drive;
      end else begin
        prog_voltage_ctl0 <= power_word[0];
        prog_voltage_ctl0_oe <= 1'b1;
        prog_voltage_ctl1 <= power_word[1];
        supply_select0_n <= ~power_word[2];
        supply_select0_n_oe <= 1'b1;
        supply_select1_n <= ~power_word[3];
        supply_select1_n_oe <= 1'b1;
      end
    end
  end

endmodule // socket_pin_sharing
`default_nettype wire

// >>> dv/power_switch_model.sv
/* Serial power switch partner model.
   Assumes link_clk is the resolved wire level of the link clock pin. */
`default_nettype none
module power_switch_model (
  input wire logic link_clk,
  input wire logic data,
  input wire logic latch,
  output logic [3:0] word,
  output int n_latch
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] shreg = 4'h0;
  // ----------------------------------------
  // Shift and strobe
  // ----------------------------------------
  initial begin
    n_latch = 0;
    word = 4'h0;
  end
  // No shift while the strobe is high, so the strobe slot is not taken as data
  always @(posedge link_clk) begin
    if (!latch) shreg <= {shreg[2:0], data};
  end
  // The word reaches the switch outputs on the strobe edge
  always @(posedge latch) begin
    word <= shreg;
    n_latch <= n_latch + 1;
  end
endmodule // power_switch_model
`default_nettype wire

// >>> dv/pin_share_props.sv
/* Port checker for the socket pin sharing block.
   Assumes it is bound to socket_pin_sharing by port name. */
`default_nettype none
module pin_share_props (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic serial_power,
  input wire logic [15:0] ctl2,
  input wire logic [3:0] power_word,
  input wire logic [1:0] socket_mode,
  input wire logic [25:16] card_addr,
  input wire logic mem_cycle,
  input wire logic io_cycle,
  input wire logic dma_cycle,
  input wire logic attr_space,
  input wire logic dma_ack,
  input wire logic cframe_n_out,
  input wire logic ccbe3_n_out,
  input wire logic [25:16] sock_addr_out,
  input wire logic [25:16] sock_addr_oe,
  input wire logic attr_sel_n_out,
  input wire logic prog_voltage_ctl0,
  input wire logic prog_voltage_ctl1,
  input wire logic supply_select0_n,
  input wire logic supply_select1_n,
  input wire logic supply_select1_n_oe
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  wire m16 = socket_mode == 2'h0;
  a_mode_via_idle: assert property (
    socket_mode != $past(socket_mode) && socket_mode != 2'h3 |-> $past(socket_mode) == 2'h3)
    else $error("mode change skipped idle");
  a_link_clk_in: assert property (
    (serial_power && !ctl2[13])[*3] |-> !supply_select1_n_oe) else $error("link clock driven");
  a_link_clk_out: assert property (
    (serial_power && ctl2[13])[*3] |-> supply_select1_n_oe) else $error("link clock not driven");
  a_parallel_lines: assert property (
    (!serial_power && $stable(power_word))[*3] |-> {supply_select1_n, supply_select0_n,
    prog_voltage_ctl1, prog_voltage_ctl0} == {~power_word[3:2], power_word[1:0]})
    else $error("parallel lines wrong");
  a_mem_attr_sel: assert property (
    m16 && mem_cycle && !dma_cycle |=> attr_sel_n_out == !$past(attr_space))
    else $error("memory space select wrong");
  a_io_attr_low: assert property (
    m16 && io_cycle && !dma_cycle && !mem_cycle |=> !attr_sel_n_out) else $error("io select high");
  a_ata_inactive: assert property (
    socket_mode == 2'h1 |=> attr_sel_n_out) else $error("select active in ata");
  a_dma_ack: assert property (
    m16 && dma_cycle |=> attr_sel_n_out == !$past(dma_ack)) else $error("dma ack wrong");
  a_cb_ctrl_map: assert property (
    socket_mode == 2'h2 |=> sock_addr_out[23] == $past(cframe_n_out)
    && attr_sel_n_out == $past(ccbe3_n_out)) else $error("cardbus control map wrong");
  a_cb_rsvd_pin: assert property (
    socket_mode == 2'h2 |=> !sock_addr_oe[18]) else $error("reserved pin driven");
  a_card16_addr: assert property (
    m16 |=> sock_addr_out == $past(card_addr)) else $error("card address wrong");
  c_cardbus: cover property (socket_mode == 2'h2);
  c_link_out: cover property (serial_power && supply_select1_n_oe);
  c_dma: cover property (m16 && dma_cycle);
endmodule // pin_share_props
bind socket_pin_sharing pin_share_props u_props (.*);
`default_nettype wire

// >>> dv/socket_pin_sharing_tb_top.sv
/* Bench for the socket pin sharing block with a serial switch model.
   Assumes the design, model and checker are compiled before it. */
`default_nettype none
module socket_pin_sharing_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // Signals, design and partner
  // ----------------------------------------
  logic ref_clk = 0, nrst = 0, serial_power = 0, link_src = 0, attr_sel_n_in = 1;
  logic mem_cycle = 0, io_cycle = 0, dma_cycle = 0, attr_space = 0, dma_ack = 0;
  logic cframe_n_out = 1, ctrdy_n_out = 1, cdevsel_n_out = 1, cstop_n_out = 1;
  logic cblock_n_out = 1, cbctl_oe = 0, ccbe3_n_out = 1, ccbe_oe = 1, card_clk_en = 0;
  logic [1:0] socket_mode_req = 2'h3, socket_mode;
  logic [15:0] ctl2 = 16'h0000;
  logic [3:0] power_word = 4'h0, got_word;
  logic [2:0] cad_out = 3'h0, cad_oe = 3'h0, cad_in;
  logic [25:16] card_addr = 10'h000, sock_addr_in = 10'h000, sock_addr_out, sock_addr_oe;
  logic link_busy, cframe_n_in, ctrdy_n_in, cdevsel_n_in, cstop_n_in, cblock_n_in, prev;
  logic attr_sel_n_out, attr_sel_n_oe, prog_voltage_ctl0, prog_voltage_ctl0_oe;
  logic prog_voltage_ctl1, supply_select0_n, supply_select0_n_oe;
  logic supply_select1_n, supply_select1_n_oe;
  // The link clock pin is shared: the device wins while it drives
  wire logic link_clk_in = supply_select1_n_oe ? supply_select1_n : link_src;
  int n_mismatch = 0, num_checks = 0, n_latch, k, i, n;
  // Row: mode, mem, io, dma, attribute or ccbe3, ack, expected select
  logic [7:0] rows [9] = '{8'h24, 8'h21, 8'h10, 8'h0A, 8'h09, 8'h51, 8'h65, 8'h80, 8'h85};
  socket_pin_sharing #(.HALF_CYC(4)) u_dut (.*);
  power_switch_model u_sw (.link_clk(link_clk_in), .data(supply_select0_n),
    .latch(prog_voltage_ctl0), .word(got_word), .n_latch(n_latch));
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  // Free reference clock, phase unrelated to ref_clk; scaled down with HALF_CYC
  initial begin
    #37;
    forever #100 link_src = ~link_src;
  end
  task step(input int c);
    repeat (c) @(posedge ref_clk);
    #2;
  endtask
  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task set_mode(input logic [1:0] m);
    socket_mode_req = m;
    for (k = 0; k < 8 && socket_mode !== m; k++) step(1);
    check("socket_mode", socket_mode, m);
  endtask
  task send_word(input logic [3:0] w);
    int nl;
    logic saw_busy;
    nl = n_latch;
    saw_busy = 0;
    power_word = w;
    // Busy must show while the word is on its way to the switch
    for (k = 0; k < 400 && n_latch == nl; k++) begin
      step(1);
      saw_busy = saw_busy | link_busy;
    end
    check("switch_word", got_word, w);
    check("link_busy", saw_busy, 1'b1);
  endtask
  // Hang guard, well beyond the expected run of a few hundred cycles
  initial begin
    #200000;
    n_mismatch++;
    close_out;
  end
  initial begin
    step(5);
    check("mode_rst", socket_mode, 2'h3);
    check("oe_rst", {sock_addr_oe, supply_select1_n_oe}, 11'h000);
    nrst = 1;
    for (i = 0; i < 9; i++) begin
      set_mode(rows[i][7:6]);
      {mem_cycle, io_cycle, dma_cycle, attr_space, dma_ack} = rows[i][5:1];
      ccbe3_n_out = rows[i][2];
      card_addr = 10'h2A5 ^ 10'(i);
      step(2);
      check("attr_sel_n_out", attr_sel_n_out, rows[i][0]);
      if (rows[i][7:6] != 2'h2) check("addr", sock_addr_out, card_addr);
    end
    {cframe_n_out, ctrdy_n_out, cdevsel_n_out, cstop_n_out, cblock_n_out} = 5'h16;
    cbctl_oe = 1;
    cad_out = 3'h5;
    cad_oe = 3'h7;
    card_clk_en = 1;
    sock_addr_in = 10'h2C9;
    step(4);
    check("cad_pins", {sock_addr_out[25:24], sock_addr_out[17]}, 3'h5);
    check("ctrl_pins", sock_addr_out[23:19], 5'h16);
    check("addr_oe", sock_addr_oe[25:17], 9'h1FD);
    check("cad_in", cad_in, 3'h4);
    check("ctrl_in", {cframe_n_in, ctrdy_n_in, cdevsel_n_in, cstop_n_in, cblock_n_in}, 5'h19);
    n = 0;
    for (i = 0; i < 40; i++) begin
      prev = sock_addr_out[16];
      step(1);
      if (sock_addr_out[16] !== prev) n++;
    end
    check("card_clk", 16'(n > 4), 16'h0001);
    socket_mode_req = 2'h0;
    step(1);
    check("via_idle", socket_mode, 2'h3);
    serial_power = 1;
    step(3);
    check("link_oe_in", supply_select1_n_oe, 1'b0);
    send_word(4'hA);
    ctl2 = 16'h2000;
    step(3);
    check("link_oe_out", supply_select1_n_oe, 1'b1);
    send_word(4'h5);
    serial_power = 0;
    power_word = 4'h6;
    step(3);
    check("parallel", {supply_select1_n, supply_select0_n, prog_voltage_ctl1,
      prog_voltage_ctl0}, 4'hA);
    nrst = 0;
    step(2);
    check("mode_rst2", socket_mode, 2'h3);
    check("oe_rst2", {sock_addr_oe, attr_sel_n_oe, prog_voltage_ctl0_oe, supply_select0_n_oe,
      supply_select1_n_oe}, 14'h0000);
    // Release again: the mode follows the request one edge later, pins one more
    nrst = 1;
    step(1);
    check("mode_rel", socket_mode, 2'h0);
    step(1);
    check("addr_rel", sock_addr_out, card_addr);
    close_out;
  end
endmodule // socket_pin_sharing_tb_top
`default_nettype wire
